// *** logic/dua_serial.sv ***
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - baud generator offers nineteen rates from 50 to 76.8k baud
// - generator produces a 16x clock for the chosen rate
// - external clock bypasses generator: 1x synchronous, 16x asynchronous
// - per-channel clock select picks generator or external clock
// - external clock: receive samples on rise, transmit changes on fall
// - transmit line stays mark when disabled, idle or in loopback
// - transmitter shifts on falling clock edge, least significant bit first
// - receiver samples on rising edge, assembles least significant first
// - request-to-send pins may follow output port bits 0 and 1
// - request-to-send may be driven automatically by receiver or transmitter
// - clear-to-send inputs are asserted low
// - ready pin of channel A is inverse of its status bit 2
// - ready pin of channel A may follow output port bit 6
// - ready pin ignores the interrupt mask
// - interrupt status shows active conditions; mask gates requests
// - interrupt request may be raised on any of seven levels
// - vector register reachable in supervisor mode only
// - with clear-to-send enabled, characters start only while it is asserted
// - two independent full-duplex channels, each with its own rate; both share the one external clock pin
module dua_serial
	import dua_pkg::*;
#(
	parameter int SETTLE_COUNT = SETTLE_EDGES
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// register port
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic supervisor_in,
	output logic [7:0] rdata_out,
	output logic access_error_out,
	// clock pins
	input wire logic osc_in,
	output logic osc_out,
	input wire logic sclk_in,
	// serial lines
	input wire logic rx_line_a_in,
	input wire logic rx_line_b_in,
	output logic tx_line_a_out,
	output logic tx_line_b_out,
	// flow control
	input wire logic clear_send_a_n_in,
	input wire logic clear_send_b_n_in,
	output logic req_send_a_n_out,
	output logic req_send_b_n_out,
	output logic tx_ready_a_n_out,
	// interrupt request
	output logic [6:0] irq_levels_out,
	output logic [7:0] irq_vector_out
);

	// --------------------------------------------------------------
	// clock sources
	// --------------------------------------------------------------
	dua_clk_if clk_if ();

	dua_baud_gen u_baud (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.osc_in(osc_in),
		.clk_if(clk_if.gen)
	);

	dua_ext_clk u_ext (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.sclk_in(sclk_in),
		.clk_if(clk_if.ext)
	);

	// crystal feedback; inverter stage toward the crystal
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			osc_out <= 1'b1;
		end else begin
			osc_out <= ~osc_in;
		end
	end

	// --------------------------------------------------------------
	// oscillator settling
	// --------------------------------------------------------------
	logic [15:0] settle_cnt;
	logic settling;

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			settle_cnt <= '0;
		end else if (clk_if.osc_tick && settling) begin
			settle_cnt <= settle_cnt + 16'h0001;
		end
	end

	assign settling = settle_cnt < 16'(SETTLE_COUNT);

	// --------------------------------------------------------------
	// bus decode
	// --------------------------------------------------------------
	logic chan_sel;
	logic ch_idx;
	logic [3:0] ch_off;
	logic vec_hit;
	logic vec_denied;

	assign chan_sel = addr_in < OUT_PORT;
	assign ch_idx = addr_in[4];
	assign ch_off = addr_in[3:0];
	assign vec_hit = addr_in == IRQ_VECTOR;
	assign vec_denied = vec_hit && !supervisor_in;

	// --------------------------------------------------------------
	// global registers
	// --------------------------------------------------------------
	logic [7:0] output_port_reg;
	logic [7:0] irq_mask_reg;
	logic [2:0] irq_level;
	logic [7:0] irq_vector;
	logic [7:0] irq_status_reg;

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			output_port_reg <= OUT_PORT_RESET;
			irq_mask_reg <= '0;
			irq_level <= '0;
			irq_vector <= VECTOR_RESET;
		end else if (wr_in) begin
			unique case (addr_in)
				OUT_PORT: output_port_reg <= wdata_in;
				IRQ_MASK: irq_mask_reg <= wdata_in;
				IRQ_LEVEL: irq_level <= wdata_in[2:0];
				IRQ_VECTOR: if (supervisor_in) irq_vector <= wdata_in;
				default: ;
			endcase
		end
	end

	// --------------------------------------------------------------
	// channels
	// --------------------------------------------------------------
	logic [7:0] ctrl [2];
	logic [7:0] clksel [2];
	logic [7:0] status [2];
	logic [7:0] rx_data [2];
	logic [1:0] tx_line;
	logic [1:0] rts_assert;
	logic [1:0] cts_n;
	logic [1:0] rx_pin;

	assign cts_n = {clear_send_b_n_in, clear_send_a_n_in};
	assign rx_pin = {rx_line_b_in, rx_line_a_in};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			logic [7:0] pend;
			logic pend_valid;
			logic [1:0] src;
			logic x1;
			logic tx_tick;
			logic rx_tick;
			logic wr_ch;
			logic rd_data;
			dua_tx_state_t tx_state;
			logic [7:0] hold;
			logic hold_full;
			logic [9:0] tx_sh;
			logic [3:0] tx_bit;
			logic [3:0] tx_sub;
			logic tx_bit_end;
			logic tx_start;
			logic tx_serial;
			dua_rx_state_t rx_state;
			logic [7:0] rx_sh;
			logic [2:0] rx_bit;
			logic [3:0] rx_sub;
			logic rx_in;
			logic rx_sample;
			logic rx_done;
			logic rx_ready;
			logic frame_err;

			assign wr_ch = wr_in && chan_sel && ch_idx == 1'(ch);
			assign rd_data = rd_in && chan_sel && ch_idx == 1'(ch) &&
				ch_off == CH_DATA;

			// control and clock select
			always_ff @(posedge clock_in) begin
				if (!resetn_in) begin
					ctrl[ch] <= CTRL_RESET;
				end else if (wr_ch && ch_off == CH_CTRL) begin
					ctrl[ch] <= wdata_in;
				end
			end

			// writes wait until the reference is stable
			always_ff @(posedge clock_in) begin
				if (!resetn_in) begin
					clksel[ch] <= CLKSEL_RESET;
					pend <= CLKSEL_RESET;
					pend_valid <= 1'b0;
				end else if (wr_ch && ch_off == CH_CLKSEL) begin
					pend <= wdata_in;
					pend_valid <= 1'b1;
				end else if (pend_valid && !settling) begin
					clksel[ch] <= pend;
					pend_valid <= 1'b0;
				end
			end

			assign clk_if.rate_sel[ch] = clksel[ch][CS_RATE_LSB +: 5];
			assign src = clksel[ch][CS_SRC_LSB +: 2];
			assign x1 = src == SRC_EXT1;
			assign tx_tick = (src == SRC_GEN) ? clk_if.rate_fall[ch] :
				clk_if.ext_fall;
			assign rx_tick = (src == SRC_GEN) ? clk_if.rate_rise[ch] :
				clk_if.ext_rise;

			// transmitter
			assign tx_bit_end = x1 || tx_sub == OVERSAMPLE_LAST;
			assign tx_start = tx_state == TX_IDLE && tx_tick &&
				ctrl[ch][CTL_TX_EN] && hold_full &&
				(!ctrl[ch][CTL_CTS_EN] || !cts_n[ch]);

			always_ff @(posedge clock_in) begin
				if (!resetn_in) begin
					hold <= '0;
					hold_full <= 1'b0;
				end else if (wr_ch && ch_off == CH_DATA) begin
					hold <= wdata_in;
					hold_full <= 1'b1;
				end else if (tx_start) begin
					hold_full <= 1'b0;
				end
			end

			always_ff @(posedge clock_in) begin
				if (!resetn_in) begin
					tx_state <= TX_IDLE;
					tx_sh <= '1;
					tx_bit <= '0;
					tx_sub <= '0;
				end else if (tx_start) begin
					tx_state <= TX_SHIFT;
					tx_sh <= {1'b1, hold, 1'b0};
					tx_bit <= '0;
					tx_sub <= '0;
				end else if (tx_state == TX_SHIFT && tx_tick) begin
					if (!tx_bit_end) begin
						tx_sub <= tx_sub + 4'h1;
					end else if (tx_bit == TX_LAST_BIT) begin
						tx_state <= TX_IDLE;
						tx_sh <= '1;
					end else begin
						tx_sub <= '0;
						tx_bit <= tx_bit + 4'h1;
						tx_sh <= {1'b1, tx_sh[9:1]};
					end
				end
			end

			assign tx_serial = (tx_state == TX_SHIFT) ? tx_sh[0] : 1'b1;

			// mark on the pin while idle, disabled or looped back
			always_ff @(posedge clock_in) begin
				if (!resetn_in) begin
					tx_line[ch] <= 1'b1;
				end else begin
					tx_line[ch] <= ctrl[ch][CTL_LOOP] | tx_serial;
				end
			end

			// receiver
			assign rx_in = ctrl[ch][CTL_LOOP] ? tx_serial : rx_pin[ch];
			assign rx_sample = rx_tick && (x1 || rx_sub == OVERSAMPLE_LAST);
			assign rx_done = rx_state == RX_STOP && rx_sample;

			always_ff @(posedge clock_in) begin
				if (!resetn_in) begin
					rx_state <= RX_IDLE;
					rx_sh <= '0;
					rx_bit <= '0;
					rx_sub <= '0;
				end else if (!ctrl[ch][CTL_RX_EN]) begin
					rx_state <= RX_IDLE;
				end else if (rx_tick) begin
					rx_sub <= rx_sub + 4'h1;
					unique case (rx_state)
						RX_IDLE: if (!rx_in) begin
							rx_sub <= '0;
							rx_bit <= '0;
							rx_state <= x1 ? RX_DATA : RX_START;
						end
						RX_START: if (rx_sub == START_CHECK) begin
							// half a bit in: a high line was a glitch
							rx_sub <= '0;
							rx_state <= rx_in ? RX_IDLE : RX_DATA;
						end
						RX_DATA: if (x1 || rx_sub == OVERSAMPLE_LAST) begin
							rx_sub <= '0;
							rx_sh <= {rx_in, rx_sh[7:1]};
							rx_bit <= rx_bit + 3'h1;
							if (rx_bit == RX_LAST_BIT) begin
								rx_state <= RX_STOP;
							end
						end
						RX_STOP: if (rx_sample) begin
							rx_state <= RX_IDLE;
						end
					endcase
				end
			end

			// a new character wins over a read in the same cycle
			always_ff @(posedge clock_in) begin
				if (!resetn_in) begin
					rx_data[ch] <= '0;
					rx_ready <= 1'b0;
					frame_err <= 1'b0;
				end else if (rx_done) begin
					rx_data[ch] <= rx_sh;
					rx_ready <= 1'b1;
					frame_err <= ~rx_in;
				end else if (rd_data) begin
					rx_ready <= 1'b0;
				end
			end

			always_comb begin
				status[ch] = '0;
				status[ch][ST_RX_READY] = rx_ready;
				status[ch][ST_RX_FULL] = rx_ready;
				status[ch][ST_TX_READY] = ctrl[ch][CTL_TX_EN] & ~hold_full;
				status[ch][ST_TX_EMPTY] = ctrl[ch][CTL_TX_EN] & ~hold_full &
					(tx_state == TX_IDLE);
				status[ch][ST_FRAME_ERR] = frame_err;
			end

			// automatic flow control
			always_comb begin
				unique case (ctrl[ch][CTL_RTS_MODE +: 2])
					RTS_RX_AUTO: rts_assert[ch] = ~rx_ready;
					RTS_TX_AUTO: rts_assert[ch] = hold_full |
						(tx_state == TX_SHIFT);
					default: rts_assert[ch] = output_port_reg[ch];
				endcase
			end
		end
	endgenerate

	assign tx_line_a_out = tx_line[0];
	assign tx_line_b_out = tx_line[1];

	// --------------------------------------------------------------
	// flow-control and ready pins
	// --------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			req_send_a_n_out <= 1'b1;
			req_send_b_n_out <= 1'b1;
			tx_ready_a_n_out <= 1'b1;
		end else begin
			req_send_a_n_out <= ctrl[0][CTL_RTS_FN] ? ~rts_assert[0] :
				output_port_reg[OP_RTS_A];
			req_send_b_n_out <= ctrl[1][CTL_RTS_FN] ? ~rts_assert[1] :
				output_port_reg[OP_RTS_B];
			// no mask term here: the pin is never gated
			tx_ready_a_n_out <= ctrl[0][CTL_TXRDY_FN] ?
				~status[0][ST_TX_READY] :
				output_port_reg[OP_TXRDY_A];
		end
	end

	// --------------------------------------------------------------
	// interrupt request
	// --------------------------------------------------------------
	always_comb begin
		irq_status_reg = '0;
		irq_status_reg[IS_TXRDY_A] = status[0][ST_TX_READY];
		irq_status_reg[IS_RXRDY_A] = status[0][ST_RX_READY];
		irq_status_reg[IS_TXRDY_B] = status[1][ST_TX_READY];
		irq_status_reg[IS_RXRDY_B] = status[1][ST_RX_READY];
		irq_status_reg[IS_OSC_SETTLE] = settling;
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			irq_levels_out <= '0;
			irq_vector_out <= VECTOR_RESET;
		end else begin
			for (int i = 0; i < 7; i++) begin
				irq_levels_out[i] <= |(irq_status_reg & irq_mask_reg) &&
					irq_level == 3'(i + 1);
			end
			irq_vector_out <= irq_vector;
		end
	end

	// --------------------------------------------------------------
	// read data
	// --------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			rdata_out <= '0;
			access_error_out <= 1'b0;
		end else begin
			access_error_out <= (rd_in || wr_in) && vec_denied;
			rdata_out <= '0;
			if (rd_in && chan_sel) begin
				unique case (ch_off)
					CH_CTRL: rdata_out <= ctrl[ch_idx];
					CH_CLKSEL: rdata_out <= clksel[ch_idx];
					CH_STATUS: rdata_out <= status[ch_idx];
					CH_DATA: rdata_out <= rx_data[ch_idx];
					default: ;
				endcase
			end else if (rd_in) begin
				unique case (addr_in)
					OUT_PORT: rdata_out <= output_port_reg;
					IRQ_STATUS: rdata_out <= irq_status_reg;
					IRQ_MASK: rdata_out <= irq_mask_reg;
					IRQ_LEVEL: rdata_out <= {5'h00, irq_level};
					IRQ_VECTOR: if (supervisor_in) rdata_out <= irq_vector;
					default: ;
				endcase
			end
		end
	end

endmodule

// *** logic/dua_pkg.sv ***
package dua_pkg;

	// --------------------------------------------------------------
	// register map (byte addresses)
	// --------------------------------------------------------------
	localparam logic [7:0] CH_STRIDE = 8'h10;
	localparam logic [3:0] CH_CTRL = 4'h0;
	localparam logic [3:0] CH_CLKSEL = 4'h4;
	localparam logic [3:0] CH_STATUS = 4'h8;
	localparam logic [3:0] CH_DATA = 4'hc;
	localparam logic [7:0] OUT_PORT = 8'h20;
	localparam logic [7:0] IRQ_STATUS = 8'h24;
	localparam logic [7:0] IRQ_MASK = 8'h28;
	localparam logic [7:0] IRQ_LEVEL = 8'h2c;
	localparam logic [7:0] IRQ_VECTOR = 8'h30;

	// --------------------------------------------------------------
	// channel control fields
	// --------------------------------------------------------------
	localparam int CTL_TX_EN = 0;
	localparam int CTL_RX_EN = 1;
	localparam int CTL_LOOP = 2;
	localparam int CTL_CTS_EN = 3;
	localparam int CTL_RTS_FN = 4;
	localparam int CTL_RTS_MODE = 5;
	localparam int CTL_TXRDY_FN = 7;
	localparam logic [1:0] RTS_MANUAL = 2'h0;
	localparam logic [1:0] RTS_RX_AUTO = 2'h1;
	localparam logic [1:0] RTS_TX_AUTO = 2'h2;

	// --------------------------------------------------------------
	// clock select fields
	// --------------------------------------------------------------
	localparam int CS_RATE_LSB = 0;
	localparam int CS_SRC_LSB = 5;
	localparam logic [1:0] SRC_GEN = 2'h0;
	localparam logic [1:0] SRC_EXT16 = 2'h1;
	localparam logic [1:0] SRC_EXT1 = 2'h2;

	// --------------------------------------------------------------
	// status fields
	// --------------------------------------------------------------
	localparam int ST_RX_READY = 0;
	localparam int ST_RX_FULL = 1;
	localparam int ST_TX_READY = 2;
	localparam int ST_TX_EMPTY = 3;
	localparam int ST_FRAME_ERR = 4;
	localparam int IS_TXRDY_A = 0;
	localparam int IS_RXRDY_A = 1;
	localparam int IS_TXRDY_B = 4;
	localparam int IS_RXRDY_B = 5;
	localparam int IS_OSC_SETTLE = 7;

	// --------------------------------------------------------------
	// output port bits
	// --------------------------------------------------------------
	localparam int OP_RTS_A = 0;
	localparam int OP_RTS_B = 1;
	localparam int OP_TXRDY_A = 6;

	// --------------------------------------------------------------
	// reset values and counts
	// --------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CLKSEL_RESET = 8'h00;
	localparam logic [7:0] OUT_PORT_RESET = 8'h00;
	localparam logic [7:0] VECTOR_RESET = 8'h0f;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
	localparam logic [3:0] START_CHECK = 4'h7;
	localparam logic [3:0] TX_LAST_BIT = 4'h9;
	localparam logic [2:0] RX_LAST_BIT = 3'h7;
	localparam int OSC_FREQ_HZ = 3686400;
	localparam int SETTLE_EDGES = 1024;
	localparam int NUM_RATES = 19;

	// osc ticks per 16x period, 50 .. 76.8k baud
	localparam logic [12:0] BAUD_DIV [NUM_RATES] = '{
		13'h1200, 13'h0c00, 13'h082f, 13'h06b1, 13'h0600, 13'h0480,
		13'h0300, 13'h0180, 13'h00db, 13'h00c0, 13'h0080, 13'h0073,
		13'h0060, 13'h0030, 13'h0020, 13'h0018, 13'h000c, 13'h0006,
		13'h0003};

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SHIFT = 2'b01
	} dua_tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b11,
		RX_STOP = 2'b10
	} dua_rx_state_t;

endpackage

// *** logic/dua_clk_if.sv ***
`timescale 1ns/100ps
interface dua_clk_if;
	logic [1:0][4:0] rate_sel;
	logic [1:0] rate_rise;
	logic [1:0] rate_fall;
	logic osc_tick;
	logic ext_rise;
	logic ext_fall;

	modport gen (input rate_sel, output rate_rise, output rate_fall,
		output osc_tick);
	modport ext (output ext_rise, output ext_fall);
	modport user (output rate_sel, input rate_rise, input rate_fall,
		input osc_tick, input ext_rise, input ext_fall);
endinterface

// *** logic/dua_baud_gen.sv ***
`timescale 1ns/100ps
module dua_baud_gen
	import dua_pkg::*;
(
	// clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// reference oscillator
	input wire logic osc_in,
	// tick carrier
	dua_clk_if.gen clk_if
);

	logic osc_prev;

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			osc_prev <= 1'b0;
		end else begin
			osc_prev <= osc_in;
		end
	end

	assign clk_if.osc_tick = osc_in & ~osc_prev;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_div
			logic [12:0] cnt;
			logic [12:0] div;
			logic [4:0] idx;

			assign idx = clk_if.rate_sel[ch];
			// out-of-range index falls back to the fastest rate
			assign div = (idx < 5'(NUM_RATES)) ? BAUD_DIV[idx] :
				BAUD_DIV[NUM_RATES - 1];

			always_ff @(posedge clock_in) begin
				if (!resetn_in) begin
					cnt <= '0;
				end else if (clk_if.osc_tick) begin
					cnt <= (cnt >= div - 13'h0001) ? '0 : cnt + 13'h0001;
				end
			end

			// 16x clock: rise at wrap, fall at half period
			assign clk_if.rate_rise[ch] = clk_if.osc_tick &&
				cnt >= div - 13'h0001;
			assign clk_if.rate_fall[ch] = clk_if.osc_tick &&
				cnt == {1'b0, div[12:1]};
		end
	endgenerate

endmodule

// *** logic/dua_ext_clk.sv ***
`timescale 1ns/100ps
module dua_ext_clk (
	// clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// external serial clock pin
	input wire logic sclk_in,
	// tick carrier
	dua_clk_if.ext clk_if
);

	logic sclk_prev;

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			sclk_prev <= 1'b1;
		end else begin
			sclk_prev <= sclk_in;
		end
	end

	assign clk_if.ext_rise = sclk_in & ~sclk_prev;
	assign clk_if.ext_fall = ~sclk_in & sclk_prev;

endmodule

// *** test/dua_serial_monitor.sv ***
`timescale 1ns/100ps
module dua_serial_monitor
	import dua_pkg::*;
(
	input logic clock_in,
	input logic resetn_in,
	input logic [7:0] addr_in,
	input logic [7:0] wdata_in,
	input logic wr_in,
	input logic rd_in,
	input logic supervisor_in,
	input logic [7:0] rdata_out,
	input logic access_error_out,
	input logic tx_line_a_out,
	input logic tx_line_b_out,
	input logic req_send_a_n_out,
	input logic tx_ready_a_n_out,
	input logic [6:0] irq_levels_out,
	input logic [7:0] irq_vector_out
);
	// ----------------------------------------
	// register shadows
	// ----------------------------------------
	logic [7:0] ctla;
	logic [7:0] op;
	logic [7:0] mask;
	logic [2:0] lvl;
	logic b_used;
	logic [1:0] up;

	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);

	// pins still show reset values for the first edges after release
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			ctla <= CTRL_RESET;
			op <= OUT_PORT_RESET;
			mask <= 8'h00;
			lvl <= 3'h0;
			b_used <= 1'b0;
			up <= 2'h0;
		end else begin
			if (up != 2'h3) begin
				up <= up + 2'h1;
			end
			if (wr_in && addr_in == {4'h0, CH_CTRL}) begin
				ctla <= wdata_in;
			end
			if (wr_in && addr_in == {4'h1, CH_CTRL} && wdata_in[CTL_TX_EN]) begin
				b_used <= 1'b1;
			end
			if (wr_in && addr_in == OUT_PORT) begin
				op <= wdata_in;
			end
			if (wr_in && addr_in == IRQ_MASK) begin
				mask <= wdata_in;
			end
			if (wr_in && addr_in == IRQ_LEVEL) begin
				lvl <= wdata_in[2:0];
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_VEC_USER_READ: assert property (
		rd_in && !supervisor_in && addr_in == IRQ_VECTOR
		|=> access_error_out && rdata_out == 8'h00)
		else $error("user read of vector not refused");
	AST_VEC_ERR_CAUSE: assert property (
		access_error_out |-> $past(rd_in || wr_in) &&
		!$past(supervisor_in) && $past(addr_in) == IRQ_VECTOR)
		else $error("access error without user vector access");
	AST_VEC_USER_WRITE: assert property (
		wr_in && !supervisor_in && addr_in == IRQ_VECTOR
		|=> $stable(irq_vector_out) [*2])
		else $error("user write changed vector");
	AST_RTS_PAR: assert property (
		up == 2'h3 && $stable(ctla) && $stable(op) && !ctla[CTL_RTS_FN]
		|-> req_send_a_n_out == op[OP_RTS_A])
		else $error("request pin not following port bit");
	AST_RDY_PAR: assert property (
		up == 2'h3 && $stable(ctla) && $stable(op) && !ctla[CTL_TXRDY_FN]
		|-> tx_ready_a_n_out == op[OP_TXRDY_A])
		else $error("ready pin not following port bit");
	AST_RDY_NO_MASK: assert property (
		wr_in && addr_in == IRQ_MASK |=> $stable(tx_ready_a_n_out) [*2])
		else $error("mask write moved ready pin");
	AST_LOOP_MARK: assert property (
		up == 2'h3 && $stable(ctla) && ctla[CTL_LOOP] |-> tx_line_a_out)
		else $error("line a not mark in loopback");
	AST_B_IDLE_MARK: assert property (
		!b_used |-> tx_line_b_out)
		else $error("line b not mark while disabled");
	AST_IRQ_MASKED: assert property (
		up == 2'h3 && $stable(mask) && mask == 8'h00
		|-> irq_levels_out == 7'h00)
		else $error("request raised with all masked");
	AST_IRQ_LEVEL: assert property (
		up == 2'h3 && $stable(lvl) && $stable(mask) && |irq_levels_out
		|-> irq_levels_out == 7'h01 << (lvl - 3'h1))
		else $error("request on wrong level");
endmodule

bind dua_serial dua_serial_monitor i_dua_serial_monitor (.clock_in,
	.resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .supervisor_in,
	.rdata_out, .access_error_out, .tx_line_a_out, .tx_line_b_out,
	.req_send_a_n_out, .tx_ready_a_n_out, .irq_levels_out,
	.irq_vector_out);

// *** test/dua_remote_term.sv ***
`timescale 1ns/100ps
module dua_remote_term (
	// clock
	input wire logic clock_in,
	// control from bench
	input wire logic go_in,
	input wire logic [7:0] char_in,
	output logic busy_out,
	output logic [11:0] seen_out,
	// line side
	input wire logic tx_line_in,
	output logic sclk_out,
	output logic rx_line_out
);
	// ----------------------------------------
	// x1 clocked frame burst
	// ----------------------------------------
	logic [11:0] frame;

	initial begin
		sclk_out = 1'b1;
		rx_line_out = 1'b1;
		busy_out = 1'b0;
		seen_out = 12'h000;
	end

	// clock stands high outside bursts, so nothing shifts unasked
	always @(posedge clock_in) begin
		if (go_in) begin
			busy_out <= 1'b1;
			frame = {3'h7, char_in, 1'b0};
			for (int i = 0; i < 12; i++) begin
				sclk_out <= 1'b0;
				rx_line_out <= frame[i];
				repeat (8) @(posedge clock_in);
				sclk_out <= 1'b1;
				repeat (8) @(posedge clock_in);
				seen_out[i] <= tx_line_in;
			end
			busy_out <= 1'b0;
		end
	end
endmodule

// *** test/dua_serial_tb.sv ***
`timescale 1ns/100ps
module dua_serial_tb
	import dua_pkg::*;
;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clock_in = 1'b0;
	logic resetn_in = 1'b0;
	logic osc_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic supervisor_in = 1'b1;
	logic clear_send_a_n_in = 1'b1;
	logic go = 1'b0;
	logic [7:0] ch = 8'h00;
	logic usr = 1'b0;
	logic sclk_in, rx_line, busy;
	logic [11:0] seen;
	logic [7:0] rdata_out, irq_vector_out;
	logic [6:0] irq_levels_out;
	logic access_error_out, osc_out, tx_line_a_out, tx_line_b_out;
	logic req_send_a_n_out, req_send_b_n_out, tx_ready_a_n_out;
	int mismatches = 0;
	int checked = 0;
	logic [7:0] opv [5] = '{8'h43, 8'h01, 8'h02, 8'h40, 8'h00};
	wire [2:0] op_pins = {req_send_a_n_out, req_send_b_n_out,
		tx_ready_a_n_out};

	always #2 clock_in = ~clock_in;
	always #135.6 osc_in = ~osc_in;

	dua_serial #(.SETTLE_COUNT(4)) i_dua_serial (.clock_in, .resetn_in,
		.addr_in, .wdata_in, .wr_in, .rd_in, .supervisor_in, .rdata_out,
		.access_error_out, .osc_in, .osc_out, .sclk_in,
		.rx_line_a_in(rx_line), .rx_line_b_in(rx_line), .tx_line_a_out,
		.tx_line_b_out, .clear_send_a_n_in, .clear_send_b_n_in(1'b0),
		.req_send_a_n_out, .req_send_b_n_out, .tx_ready_a_n_out,
		.irq_levels_out, .irq_vector_out);

	dua_remote_term i_dua_remote_term (.clock_in(clock_in), .go_in(go),
		.char_in(ch), .busy_out(busy), .seen_out(seen),
		.tx_line_in(tx_line_a_out), .sclk_out(sclk_in),
		.rx_line_out(rx_line));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input logic [11:0] s, input logic [11:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask

	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		supervisor_in <= !usr;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask

	task rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_in);
		addr_in <= a;
		supervisor_in <= !usr;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1;
		d = rdata_out;
	endtask

	task rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd_reg(a, d);
		chk(d, e);
	endtask

	task tick(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask

	// bounded, so a dead partner cannot hang the sequence
	task burst(input logic [7:0] c);
		int n;
		@(posedge clock_in);
		ch <= c;
		go <= 1'b1;
		@(posedge clock_in);
		go <= 1'b0;
		n = 0;
		#1;
		while (busy && n < 400) begin
			@(posedge clock_in);
			n++;
		end
		#1;
	endtask

	task give_verdict();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clock_in);
		mismatches++;
		give_verdict();
	end

	initial begin
		logic [7:0] d;
		int n;
		repeat (4) @(posedge clock_in);
		#1;
		chk({op_pins, tx_line_a_out, tx_line_b_out, irq_levels_out}, 12'hf80);
		chk({osc_out, irq_vector_out}, {1'b1, VECTOR_RESET});
		@(posedge clock_in) resetn_in <= 1'b1;
		$display("done: reset");
		rd_reg(IRQ_STATUS, d);
		chk(d[IS_OSC_SETTLE], 1'b1);
		wr_reg({4'h0, CH_CLKSEL}, 8'h40);
		wr_reg({4'h1, CH_CLKSEL}, 8'h52);
		rchk({4'h0, CH_CLKSEL}, CLKSEL_RESET);
		n = 0;
		do begin
			rd_reg(IRQ_STATUS, d);
			n++;
		end while (d[IS_OSC_SETTLE] !== 1'b0 && n < 500);
		chk(d[IS_OSC_SETTLE], 1'b0);
		tick(2);
		rchk({4'h0, CH_CLKSEL}, {1'b0, SRC_EXT1, 5'h00});
		rchk({4'h1, CH_CLKSEL}, {1'b0, SRC_EXT1, 5'h12});
		rchk(IRQ_VECTOR, VECTOR_RESET);
		usr = 1'b1;
		wr_reg(IRQ_VECTOR, 8'h55);
		rd_reg(IRQ_VECTOR, d);
		chk({d, 3'h0, access_error_out}, 12'h001);
		usr = 1'b0;
		rchk(IRQ_VECTOR, VECTOR_RESET);
		rchk(8'h3c, 8'h00);
		$display("done: access");
		foreach (opv[i]) begin
			wr_reg(OUT_PORT, opv[i]);
			tick(2);
			chk(op_pins, {opv[i][0], opv[i][1], opv[i][6]});
		end
		wr_reg({4'h0, CH_CTRL}, 8'h81);
		tick(2);
		chk(tx_ready_a_n_out, 1'b0);
		rd_reg({4'h0, CH_STATUS}, d);
		chk(d[ST_TX_READY], 1'b1);
		wr_reg(IRQ_MASK, 8'h01);
		tick(2);
		chk(tx_ready_a_n_out, 1'b0);
		for (int lv = 1; lv < 8; lv++) begin
			wr_reg(IRQ_LEVEL, 8'(lv));
			tick(2);
			chk(irq_levels_out, 7'h01 << (lv - 1));
		end
		rd_reg(IRQ_STATUS, d);
		chk(d[IS_TXRDY_A], 1'b1);
		wr_reg(IRQ_MASK, 8'h00);
		tick(2);
		chk(irq_levels_out, 7'h00);
		$display("done: pins and requests");
		wr_reg({4'h0, CH_CTRL}, 8'h89);
		wr_reg({4'h0, CH_DATA}, 8'ha5);
		tick(2);
		chk(tx_ready_a_n_out, 1'b1);
		burst(8'h5a);
		chk(seen, 12'hfff);
		wr_reg({4'h0, CH_CTRL}, 8'hbb);
		wr_reg({4'h1, CH_CTRL}, 8'h02);
		wr_reg(IRQ_MASK, 8'h02);
		wr_reg(IRQ_LEVEL, 8'h03);
		tick(2);
		chk(req_send_a_n_out, 1'b0);
		@(posedge clock_in) clear_send_a_n_in <= 1'b0;
		burst(8'h3c);
		chk(seen, {3'h7, 8'ha5, 1'b0});
		chk({req_send_a_n_out, irq_levels_out}, 8'h84);
		rchk({4'h0, CH_DATA}, 8'h3c);
		rchk({4'h1, CH_DATA}, 8'h3c);
		tick(2);
		chk(irq_levels_out, 7'h00);
		wr_reg({4'h0, CH_CTRL}, 8'h07);
		wr_reg({4'h0, CH_DATA}, 8'h96);
		burst(8'h00);
		chk(seen, 12'hfff);
		rchk({4'h0, CH_DATA}, 8'h96);
		$display("done: serial");
		give_verdict();
	end
endmodule
